// [rtl/gps_cfg.svh]
// gps_cfg: addresses, fields, defaults, commands and timing of the parameter store
// assumes: included by bare name from gps_dev and gps_host
`ifndef GPS_CFG_SVH
`define GPS_CFG_SVH
// device byte addresses
`define GPS_ADDR_SERIAL 8'h00
`define GPS_ADDR_SLOT 8'h02
`define GPS_ADDR_TCAL 8'h04
`define GPS_ADDR_TOUT 8'h09
`define GPS_ADDR_QUAD 8'h2E
`define GPS_ADDR_BL 8'h2F
`define GPS_ADDR_BC 8'h30
`define GPS_ADDR_SL 8'h31
`define GPS_ADDR_SC 8'h32
`define GPS_ADDR_MIDT 8'h33
// array slots
`define GPS_NREG 10
`define GPS_IDX_SERIAL 4'h0
`define GPS_IDX_SLOT 4'h1
`define GPS_IDX_TCAL 4'h2
`define GPS_IDX_TOUT 4'h3
`define GPS_IDX_QUAD 4'h4
`define GPS_IDX_BL 4'h5
`define GPS_IDX_BC 4'h6
`define GPS_IDX_SL 4'h7
`define GPS_IDX_SC 4'h8
`define GPS_IDX_MIDT 4'h9
`define GPS_IDX_NONE 4'hF
// fields
`define GPS_F_SLOT 15:8
`define GPS_F_SLOT_LOW 14:8
`define GPS_B_RAW_SEL 27
`define GPS_B_TCAL_EN 2
`define GPS_F_TOFF 27:16
`define GPS_F_TGAIN 13:2
`define GPS_F_SQ 31:16
`define GPS_F_BQ 15:0
`define GPS_F_COEF 29:0
`define GPS_F_MIDT 19:0
// defaults
`define GPS_DEF_SLOT 32'h0000_0100
`define GPS_DEF_TCAL 32'h0000_2000
`define GPS_DEF_SC 32'h0800_0000
`define GPS_DEF_ZERO 32'h0000_0000
// arbitrary serial number, not a real part's
`define GPS_SERIAL_DEF 30'h0123_4567
// programming limits
`define GPS_LIM_NONE 3'h0
`define GPS_LIM_ONCE 3'h1
`define GPS_LIM_RATE 3'h7
// compensation scaling
`define GPS_SF_SETTING 10000
`define GPS_TEMP_SHIFT 8
`define GPS_SC_EXP 27
`define GPS_SL_EXP 46
`define GPS_SQ_EXP 55
`define GPS_BL_EXP 35
`define GPS_BQ_EXP 39
`define GPS_TGAIN_EXP 9
// instructions and frame lengths in bits
`define GPS_INS_RATE 8'h50
`define GPS_INS_TEMP 8'h54
`define GPS_INS_READ 8'h58
`define GPS_INS_WRITE 8'h78
`define GPS_INS_RDREQ 8'h7C
`define GPS_LEN_INS 7'h08
`define GPS_LEN_2 7'h18
`define GPS_LEN_4 7'h28
`define GPS_LEN_8 7'h48
// timing
`define GPS_CLK_NS 100
`define GPS_SCLK_HALF_NS 800
`define GPS_SCLK_HALF_CYC (`GPS_SCLK_HALF_NS / `GPS_CLK_NS)
// host register map
`define GPS_H_CMD 8'h00
`define GPS_H_STAT 8'h04
`define GPS_H_ARGH 8'h08
`define GPS_H_ARGL 8'h0C
`define GPS_H_RXH 8'h10
`define GPS_H_RXL 8'h14
`define GPS_RESP_OKAY 2'h0
`define GPS_RESP_SLVERR 2'h2
`endif

// [rtl/gps_dev.sv]
// gps_dev: sensor end, serial slave with volatile registers, nv store, rate compensation
// assumes: link pins asynchronous to CLK, sclk well below CLK/8; samples on CLK
//
// Decided for this implementation: register access over AXI4-Lite.
`include "gps_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - volatile registers other than 0x00 rewritable freely, cleared by reset
// - nv writes persist across reset, replace value
// - rate coefficients and slot counter seven programmings, 0x04 and 0x09 one, serial none
// - serial commands read and write both stores
// - bit 2 at 0x09 selects calibrated temperature
// - temperature offset bits 27:16 at 0x04
// - temperature gain bits 13:2, default 0x800
// - bit 27 at 0x02 selects raw rate
// - 0x2E holds quadratic scale and bias
// - linear and constant bias at 0x2F, 0x30
// - linear and constant scale at 0x31, 0x32
// - slot counter thermometer code at 0x02
// - host rewrites neighbour bits unchanged
// - serial number readable at 0x00 bits 30:1
// - rate minus bias over scale polynomial
// - polynomials in temp times 256 minus midpoint
// - signed coefficients with fixed binary scalings
// - host selects raw rate before calibration
// - compensation applied to filtered rate
// - link runs in clock mode zero only
// - instruction byte then 2, 4, 8 bytes
// - new nv coefficients effective after next reset
module gps_dev #(
  parameter int NREG = `GPS_NREG,
  parameter logic [29:0] SERIAL = `GPS_SERIAL_DEF
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // serial link
  gps_spi_if.dev SPI,
  // filtered sensor samples
  input wire logic [23:0] RAW_RATE,
  input wire logic [11:0] RAW_TEMP,
  input wire logic SAMPLE_STB,
  input wire logic SELF_TEST_OK,
  // results
  output logic [23:0] RATE_OUT,
  output logic [15:0] TEMP_OUT,
  output logic RATE_READY,
  output logic BOOT_DONE
);
  gps_pkg::gps_word_t sys_ff [NREG];
  gps_pkg::gps_word_t nv_mem [NREG];
  logic [2:0] pin_q;
  logic sclk_d_ff, csn_d_ff;
  logic sclk_rise, sclk_fall, csn_rise, csn_fall;
  logic [6:0] bit_cnt_ff;
  logic [7:0] instr_ff;
  logic [63:0] arg_ff;
  logic [31:0] tx_ff, resp, rd_data_ff;
  logic miso_ff, miso_oe_ff, st_ff;
  logic do_write, do_rdreq, do_rate_rd, w_nv, r_nv, slot_ok;
  logic [3:0] w_idx, r_idx, boot_idx_ff;
  logic [31:0] w_data;
  logic signed [63:0] dt_w, dt2_w, bias_w, sfq_w, num_w, quo_w;
  logic [23:0] comp_rate;
  logic [31:0] tcal_w;

  function automatic logic [3:0] idx_of(input logic [7:0] a);
    case (a)
      `GPS_ADDR_SERIAL: idx_of = `GPS_IDX_SERIAL;
      `GPS_ADDR_SLOT: idx_of = `GPS_IDX_SLOT;
      `GPS_ADDR_TCAL: idx_of = `GPS_IDX_TCAL;
      `GPS_ADDR_TOUT: idx_of = `GPS_IDX_TOUT;
      `GPS_ADDR_QUAD: idx_of = `GPS_IDX_QUAD;
      `GPS_ADDR_BL: idx_of = `GPS_IDX_BL;
      `GPS_ADDR_BC: idx_of = `GPS_IDX_BC;
      `GPS_ADDR_SL: idx_of = `GPS_IDX_SL;
      `GPS_ADDR_SC: idx_of = `GPS_IDX_SC;
      `GPS_ADDR_MIDT: idx_of = `GPS_IDX_MIDT;
      default: idx_of = `GPS_IDX_NONE;
    endcase
  endfunction

  function automatic logic [2:0] lim_of(input logic [3:0] i);
    case (i)
      `GPS_IDX_SERIAL: lim_of = `GPS_LIM_NONE;
      `GPS_IDX_TCAL, `GPS_IDX_TOUT: lim_of = `GPS_LIM_ONCE;
      default: lim_of = `GPS_LIM_RATE;
    endcase
  endfunction

  function automatic logic [31:0] nv_default(input logic [3:0] i);
    case (i)
      `GPS_IDX_SERIAL: nv_default = {1'b0, SERIAL, 1'b0};
      `GPS_IDX_SLOT: nv_default = `GPS_DEF_SLOT;
      `GPS_IDX_TCAL: nv_default = `GPS_DEF_TCAL;
      `GPS_IDX_SC: nv_default = `GPS_DEF_SC;
      default: nv_default = `GPS_DEF_ZERO;
    endcase
  endfunction

  // link pins into the clock domain
  gps_sync #(.W(3), .INIT(3'b100)) u_sync (
    .clk(CLK),
    .rst_n(RESETN),
    .d({SPI.csn, SPI.sclk, SPI.mosi}),
    .q_ff(pin_q)
  );

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sclk_d_ff <= 1'b0;
      csn_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= pin_q[1];
      csn_d_ff <= pin_q[2];
    end
  end

  // mode zero: sample on rising, shift on falling
  assign sclk_rise = pin_q[1] & ~sclk_d_ff & ~pin_q[2];
  assign sclk_fall = ~pin_q[1] & sclk_d_ff & ~pin_q[2];
  assign csn_rise = pin_q[2] & ~csn_d_ff;
  assign csn_fall = ~pin_q[2] & csn_d_ff;

  // frame capture: instruction byte then argument
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bit_cnt_ff <= 7'h00;
      instr_ff <= 8'h00;
      arg_ff <= 64'h0;
    end else if (csn_fall) begin
      bit_cnt_ff <= 7'h00;
    end else if (sclk_rise) begin
      if (bit_cnt_ff != `GPS_LEN_8 + `GPS_LEN_INS)
        bit_cnt_ff <= bit_cnt_ff + 7'h01;
      if (bit_cnt_ff < `GPS_LEN_INS)
        instr_ff <= {instr_ff[6:0], pin_q[0]};
      else
        arg_ff <= {arg_ff[62:0], pin_q[0]};
    end
  end

  // commands act at frame end only with the exact length
  assign do_write = csn_rise & BOOT_DONE & (instr_ff == `GPS_INS_WRITE)
                    & (bit_cnt_ff == `GPS_LEN_8);
  assign do_rdreq = csn_rise & BOOT_DONE & (instr_ff == `GPS_INS_RDREQ)
                    & (bit_cnt_ff == `GPS_LEN_2);
  assign do_rate_rd = csn_rise & (instr_ff == `GPS_INS_RATE) & (bit_cnt_ff == `GPS_LEN_4);
  assign w_nv = arg_ff[56];
  assign w_idx = idx_of(arg_ff[55:48]);
  assign w_data = arg_ff[31:0];
  assign r_nv = arg_ff[8];
  assign r_idx = idx_of(arg_ff[7:0]);
  // slot counter may only gain one set bit from the bottom
  assign slot_ok = (w_idx != `GPS_IDX_SLOT)
                   | (w_data[`GPS_F_SLOT] == {nv_mem[`GPS_IDX_SLOT][`GPS_F_SLOT_LOW], 1'b1});

  // nv store: no reset, each cell counts its programmings
  for (genvar g = 0; g < NREG; g++) begin : g_nv
    gps_pkg::gps_word_t cell_ff = nv_default(4'(g));
    logic [2:0] used_ff = `GPS_LIM_NONE;
    logic allow;
    assign allow = do_write & w_nv & (w_idx == 4'(g)) & slot_ok
                   & (used_ff < lim_of(4'(g)));
    always_ff @(posedge CLK) begin
      if (allow) begin
        cell_ff <= w_data;
        used_ff <= used_ff + 3'h1;
      end
    end
    assign nv_mem[g] = cell_ff;
  end

  // volatile registers: cleared by reset, then loaded from the nv store
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      boot_idx_ff <= 4'h0;
      BOOT_DONE <= 1'b0;
      for (int i = 0; i < NREG; i++)
        sys_ff[i] <= `GPS_DEF_ZERO;
    end else if (!BOOT_DONE) begin
      sys_ff[boot_idx_ff] <= nv_mem[boot_idx_ff];
      boot_idx_ff <= boot_idx_ff + 4'h1;
      if (boot_idx_ff == 4'(NREG - 1))
        BOOT_DONE <= 1'b1;
    end else if (do_write && !w_nv && w_idx != `GPS_IDX_NONE && w_idx != `GPS_IDX_SERIAL) begin
      sys_ff[w_idx] <= w_data;
    end
  end

  // read request latches a word for the next read frame
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN)
      rd_data_ff <= `GPS_DEF_ZERO;
    else if (do_rdreq) begin
      if (r_idx == `GPS_IDX_NONE)
        rd_data_ff <= `GPS_DEF_ZERO;
      else
        rd_data_ff <= r_nv ? nv_mem[r_idx] : sys_ff[r_idx];
    end
  end

  // answer of the current instruction
  always_comb begin
    case (instr_ff)
      `GPS_INS_RATE: resp = {RATE_OUT, 6'h00, st_ff, RATE_READY};
      `GPS_INS_TEMP: resp = {TEMP_OUT, 16'h0000};
      `GPS_INS_READ: resp = rd_data_ff;
      default: resp = `GPS_DEF_ZERO;
    endcase
  end

  // miso shifts on falling edges, driven only while selected
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_ff <= 32'h0;
      miso_ff <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else begin
      miso_oe_ff <= ~pin_q[2];
      if (csn_fall) begin
        tx_ff <= 32'h0;
        miso_ff <= 1'b0;
      end else if (sclk_fall) begin
        if (bit_cnt_ff == `GPS_LEN_INS) begin
          miso_ff <= resp[31];
          tx_ff <= {resp[30:0], 1'b0};
        end else begin
          miso_ff <= tx_ff[31];
          tx_ff <= {tx_ff[30:0], 1'b0};
        end
      end
    end
  end
  assign SPI.miso = miso_ff;
  assign SPI.miso_oe = miso_oe_ff;

  // compensation of the filtered rate
  always_comb begin
    dt_w = $signed({44'h0, RAW_TEMP, 8'h00})
           - $signed({44'h0, sys_ff[`GPS_IDX_MIDT][`GPS_F_MIDT]});
    dt2_w = dt_w * dt_w;
    bias_w = 64'(signed'(sys_ff[`GPS_IDX_BC][`GPS_F_COEF]))
             + ((64'(signed'(sys_ff[`GPS_IDX_BL][`GPS_F_COEF])) * dt_w) >>> `GPS_BL_EXP)
             + ((64'(signed'(sys_ff[`GPS_IDX_QUAD][`GPS_F_BQ])) * dt2_w) >>> `GPS_BQ_EXP);
    sfq_w = 64'(signed'(sys_ff[`GPS_IDX_SC][`GPS_F_COEF]))
            + ((64'(signed'(sys_ff[`GPS_IDX_SL][`GPS_F_COEF])) * dt_w)
               >>> (`GPS_SL_EXP - `GPS_SC_EXP))
            + ((64'(signed'(sys_ff[`GPS_IDX_QUAD][`GPS_F_SQ])) * dt2_w)
               >>> (`GPS_SQ_EXP - `GPS_SC_EXP));
    num_w = ($signed({{40{RAW_RATE[23]}}, RAW_RATE}) - bias_w) <<< `GPS_SC_EXP;
    quo_w = (sfq_w == 64'sh0) ? 64'sh0 : num_w / sfq_w;
    if (quo_w > 64'sh7F_FFFF)
      comp_rate = 24'h7F_FFFF;
    else if (quo_w < -64'sh80_0000)
      comp_rate = 24'h80_0000;
    else
      comp_rate = quo_w[23:0];
    tcal_w = ((32'(sys_ff[`GPS_IDX_TCAL][`GPS_F_TGAIN]) * 32'(RAW_TEMP)) >> `GPS_TGAIN_EXP)
             + 32'(sys_ff[`GPS_IDX_TCAL][`GPS_F_TOFF]);
  end

  // sample outputs and self-test flag
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RATE_OUT <= 24'h00_0000;
      TEMP_OUT <= 16'h0000;
      st_ff <= 1'b0;
    end else if (SAMPLE_STB && BOOT_DONE) begin
      RATE_OUT <= sys_ff[`GPS_IDX_SLOT][`GPS_B_RAW_SEL] ? RAW_RATE : comp_rate;
      TEMP_OUT <= sys_ff[`GPS_IDX_TOUT][`GPS_B_TCAL_EN] ? tcal_w[15:0] : {4'h0, RAW_TEMP};
      st_ff <= SELF_TEST_OK;
    end
  end

  // a new sample beats a read that ends in the same cycle
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN)
      RATE_READY <= 1'b0;
    else if (SAMPLE_STB && BOOT_DONE)
      RATE_READY <= 1'b1;
    else if (do_rate_rd)
      RATE_READY <= 1'b0;
  end
endmodule // gps_dev
`default_nettype wire

// [rtl/gps_host.sv]
// gps_host: host controller, axi4-lite registers in, serial frames out
// assumes: one outstanding write and one outstanding read on the bus
`include "gps_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module gps_host #(
  parameter int HALF = `GPS_SCLK_HALF_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // axi4-lite write
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // serial link
  gps_spi_if.host SPI
);
  gps_pkg::gps_host_state_t state_ff;
  logic [7:0] awaddr_ff, cmd_ff, div_ff;
  logic [31:0] wdata_ff, arg_hi_ff, arg_lo_ff;
  logic [3:0] wstrb_ff, nbytes;
  logic aw_full_ff, w_full_ff, wr_go, start, half_done, miso_q;
  logic sclk_ff, csn_ff;
  logic [6:0] bit_cnt_ff, nbits_ff;
  logic [71:0] tx_ff;
  logic [63:0] rx_ff;

  function automatic logic [3:0] bytes_of(input logic [7:0] ins);
    case (ins)
      `GPS_INS_WRITE: bytes_of = 4'h8;
      `GPS_INS_RATE, `GPS_INS_READ: bytes_of = 4'h4;
      `GPS_INS_TEMP, `GPS_INS_RDREQ: bytes_of = 4'h2;
      default: bytes_of = 4'h0;
    endcase
  endfunction

  gps_sync #(.W(1), .INIT(1'b1)) u_sync (
    .clk(CLK),
    .rst_n(RESETN),
    .d(SPI.miso_line),
    .q_ff(miso_q)
  );

  // write channel: address and data taken in either order
  assign wr_go = aw_full_ff & w_full_ff & ~BVALID;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= `GPS_RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        awaddr_ff <= AWADDR;
        aw_full_ff <= 1'b1;
        AWREADY <= 1'b0;
      end
      if (WVALID && WREADY) begin
        wdata_ff <= WDATA;
        wstrb_ff <= WSTRB;
        w_full_ff <= 1'b1;
        WREADY <= 1'b0;
      end
      if (wr_go) begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        BVALID <= 1'b1;
        case (awaddr_ff)
          `GPS_H_CMD, `GPS_H_ARGH, `GPS_H_ARGL: BRESP <= `GPS_RESP_OKAY;
          default: BRESP <= `GPS_RESP_SLVERR;
        endcase
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  // argument registers with byte strobes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      arg_hi_ff <= 32'h0;
      arg_lo_ff <= 32'h0;
    end else if (wr_go) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_ff[b] && awaddr_ff == `GPS_H_ARGH)
          arg_hi_ff[8*b +: 8] <= wdata_ff[8*b +: 8];
        if (wstrb_ff[b] && awaddr_ff == `GPS_H_ARGL)
          arg_lo_ff[8*b +: 8] <= wdata_ff[8*b +: 8];
      end
    end
  end

  // read channel
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= `GPS_RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RRESP <= `GPS_RESP_OKAY;
      case (ARADDR)
        `GPS_H_CMD: RDATA <= {24'h0, cmd_ff};
        `GPS_H_STAT: RDATA <= {31'h0, state_ff != gps_pkg::GPS_H_IDLE};
        `GPS_H_ARGH: RDATA <= arg_hi_ff;
        `GPS_H_ARGL: RDATA <= arg_lo_ff;
        `GPS_H_RXH: RDATA <= rx_ff[63:32];
        `GPS_H_RXL: RDATA <= rx_ff[31:0];
        default: begin
          RDATA <= 32'h0;
          RRESP <= `GPS_RESP_SLVERR;
        end
      endcase
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // frame engine: clock mode zero, sclk divided from CLK
  assign nbytes = bytes_of(wdata_ff[7:0]);
  assign start = wr_go & (awaddr_ff == `GPS_H_CMD) & wstrb_ff[0]
                 & (state_ff == gps_pkg::GPS_H_IDLE) & (nbytes != 4'h0);
  assign half_done = div_ff == 8'(HALF - 1);
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_ff <= gps_pkg::GPS_H_IDLE;
      div_ff <= 8'h00;
      bit_cnt_ff <= 7'h00;
      nbits_ff <= 7'h00;
      tx_ff <= 72'h0;
      rx_ff <= 64'h0;
      cmd_ff <= 8'h00;
      sclk_ff <= 1'b0;
      csn_ff <= 1'b1;
    end else begin
      div_ff <= (state_ff == gps_pkg::GPS_H_IDLE || half_done) ? 8'h00 : div_ff + 8'h01;
      case (state_ff)
        gps_pkg::GPS_H_IDLE: begin
          if (start) begin
            cmd_ff <= wdata_ff[7:0];
            csn_ff <= 1'b0;
            bit_cnt_ff <= 7'h00;
            nbits_ff <= 7'({nbytes, 3'b000}) + `GPS_LEN_INS;
            case (nbytes)
              4'h8: tx_ff <= {wdata_ff[7:0], arg_hi_ff, arg_lo_ff};
              4'h4: tx_ff <= {wdata_ff[7:0], arg_lo_ff, 32'h0};
              default: tx_ff <= {wdata_ff[7:0], arg_lo_ff[15:0], 48'h0};
            endcase
            state_ff <= gps_pkg::GPS_H_LOW;
          end
        end
        gps_pkg::GPS_H_LOW: begin
          if (half_done) begin
            sclk_ff <= 1'b1;
            rx_ff <= {rx_ff[62:0], miso_q};
            bit_cnt_ff <= bit_cnt_ff + 7'h01;
            state_ff <= gps_pkg::GPS_H_HIGH;
          end
        end
        gps_pkg::GPS_H_HIGH: begin
          if (half_done) begin
            sclk_ff <= 1'b0;
            if (bit_cnt_ff == nbits_ff)
              state_ff <= gps_pkg::GPS_H_TAIL;
            else begin
              tx_ff <= {tx_ff[70:0], 1'b0};
              state_ff <= gps_pkg::GPS_H_LOW;
            end
          end
        end
        gps_pkg::GPS_H_TAIL: begin
          if (half_done) begin
            csn_ff <= 1'b1;
            state_ff <= gps_pkg::GPS_H_GAP;
          end
        end
        gps_pkg::GPS_H_GAP: begin
          if (half_done)
            state_ff <= gps_pkg::GPS_H_IDLE;
        end
        default: state_ff <= gps_pkg::GPS_H_IDLE;
      endcase
    end
  end
  assign SPI.sclk = sclk_ff;
  assign SPI.csn = csn_ff;
  assign SPI.mosi = tx_ff[71];
endmodule // gps_host
`default_nettype wire

// [rtl/gps_pkg.sv]
// gps_pkg: shared types of the parameter store link
// assumes: compiled before every other design file
package gps_pkg;
  typedef logic [31:0] gps_word_t;
  typedef enum logic [4:0] {
    GPS_H_IDLE = 5'h01,
    GPS_H_LOW = 5'h02,
    GPS_H_HIGH = 5'h04,
    GPS_H_TAIL = 5'h08,
    GPS_H_GAP = 5'h10
  } gps_host_state_t;
endpackage

// [rtl/gps_spi_if.sv]
// gps_spi_if: serial link between host controller and sensor device
// assumes: miso line pulled high when the device does not drive it
`timescale 1ns/1ns
`default_nettype none
interface gps_spi_if;
  logic sclk;
  logic csn;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  assign miso_line = miso_oe ? miso : 1'b1;
  modport dev (input sclk, input csn, input mosi, output miso, output miso_oe);
  modport host (output sclk, output csn, output mosi, input miso_line);
endinterface
`default_nettype wire

// [rtl/gps_sync.sv]
// gps_sync: two-stage synchroniser for levels from another clock domain
// assumes: each bit is an independent level
`timescale 1ns/1ns
`default_nettype none
module gps_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q_ff
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= INIT;
      q_ff <= INIT;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
endmodule // gps_sync
`default_nettype wire

// [sim/gps_spi_monitor.sv]
// gps_spi_monitor: assertions on the serial link between host and device
// assumes: placed beside the link interface, host half period of 8 clocks
`timescale 1ns/1ns
`default_nettype none
module gps_spi_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // link
  input wire logic sclk,
  input wire logic csn,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  logic [6:0] bits_ff;
  // rising serial clock edges within a frame
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bits_ff <= 7'h00;
    end else if (csn) begin
      bits_ff <= 7'h00;
    end else if ($rose(sclk)) begin
      bits_ff <= bits_ff + 7'h01;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  chk_sclk_idle_low: assert property (csn |-> !sclk)
    else $error("serial clock high outside a frame");
  chk_mosi_held_high: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("mosi moved while clock high");
  chk_miso_held_high: assert property (sclk && $past(sclk) |-> $stable(miso_line))
    else $error("miso moved while clock high");
  chk_sclk_high_len: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("clock high phase not 8 cycles");
  chk_sclk_low_len: assert property ($fell(sclk) |-> (!sclk)[*8])
    else $error("clock low phase too short");
  chk_frame_lead: assert property ($fell(csn) |-> (!sclk)[*8])
    else $error("clock moved too soon after select");
  chk_frame_gap: assert property ($rose(csn) |-> csn[*8])
    else $error("gap between frames too short");
  chk_frame_bit_count: assert property ($rose(csn) |->
    (bits_ff == 7'h18 || bits_ff == 7'h28 || bits_ff == 7'h48))
    else $error("frame length not 2, 4 or 8 argument bytes");
  chk_miso_drive_on: assert property ($fell(csn) |-> ##[1:4] (miso_oe && !miso))
    else $error("miso not driven in frame");
  chk_miso_release: assert property ($rose(csn) |-> ##[1:4] (!miso_oe && miso_line))
    else $error("miso not released after frame");
  cover property ($rose(csn) && bits_ff == 7'h48);
  cover property ($rose(csn) && bits_ff == 7'h28);
  cover property ($rose(csn) && bits_ff == 7'h18);
endmodule // gps_spi_monitor
`default_nettype wire

// [sim/testbench.sv]
// testbench: host and device joined by the link, driven over the host bus
// assumes: design files compiled first, nv store starts at its defaults
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic CLK = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, boot_done;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [23:0] raw_rate = 24'h0;
  logic [11:0] raw_temp = 12'h0;
  logic sample_stb = 1'b0, self_test_ok = 1'b1;
  int fails = 0, samples_checked = 0, cyc = 0;
  logic [7:0] adr [10] = '{8'h00, 8'h02, 8'h04, 8'h09, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33};
  logic [31:0] dfl [10] = '{32'h0246_8ACE, 32'h100, 32'h2000, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0800_0000, 32'h0};
  gps_spi_if spi_if ();
  gps_host i_gps_host (.CLK(CLK), .RESETN(resetn), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .SPI(spi_if.host));
  gps_dev i_gps_dev (.CLK(CLK), .RESETN(resetn), .SPI(spi_if.dev), .RAW_RATE(raw_rate),
    .RAW_TEMP(raw_temp), .SAMPLE_STB(sample_stb), .SELF_TEST_OK(self_test_ok),
    .RATE_OUT(), .TEMP_OUT(), .RATE_READY(), .BOOT_DONE(boot_done));
  gps_spi_monitor i_gps_spi_monitor (.CLK(CLK), .RESETN(resetn), .sclk(spi_if.sclk),
    .csn(spi_if.csn), .mosi(spi_if.mosi), .miso(spi_if.miso), .miso_oe(spi_if.miso_oe),
    .miso_line(spi_if.miso_line));
  always #50 CLK = ~CLK;
  task report_and_stop;
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 95000) begin
      fails++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge CLK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge CLK);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge CLK);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge CLK);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task frame(input logic [7:0] ins, input logic [31:0] h, input logic [31:0] l);
    logic [1:0] r;
    logic [31:0] s;
    axw(8'h08, h, r);
    axw(8'h0C, l, r);
    axw(8'h00, {24'h0, ins}, r);
    do begin
      axr(8'h04, s, r);
    end while (s[0] !== 1'b0);
  endtask
  task devwr(input logic nv, input logic [7:0] a, input logic [31:0] d);
    frame(8'h78, {7'h0, nv, a, 16'h0}, d);
  endtask
  task rdchk(input logic nv, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    frame(8'h7C, 32'h0, {16'h0, 7'h0, nv, a});
    frame(8'h58, 32'h0, 32'h0);
    axr(8'h14, d, r);
    chk(d, e);
  endtask
  task samp(input logic [23:0] v, input logic [11:0] t);
    @(posedge CLK);
    raw_rate <= v;
    raw_temp <= t;
    sample_stb <= 1'b1;
    @(posedge CLK);
    sample_stb <= 1'b0;
    repeat (8) @(posedge CLK);
  endtask
  task rxchk(input logic [7:0] ins, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    frame(ins, 32'h0, 32'h0);
    axr(8'h14, d, r);
    chk(d & m, e);
  endtask
  task rst;
    @(posedge CLK);
    resetn <= 1'b0;
    repeat (16) @(posedge CLK);
    resetn <= 1'b1;
    repeat (12) @(posedge CLK);
    chk({31'h0, boot_done}, 32'h1);
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    rst();
    foreach (adr[i]) rdchk(1'b0, adr[i], dfl[i]);
    rdchk(1'b1, 8'h02, 32'h100);
    axw(8'h18, 32'h1, r);
    chk({30'h0, r}, 32'h2);
    axr(8'h18, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h2);
    devwr(1'b0, 8'h04, 32'h0003_2000);
    devwr(1'b0, 8'h09, 32'h4);
    samp(24'h123456, 12'h123);
    rxchk(8'h54, 32'hFFFF, 32'h048F);
    devwr(1'b0, 8'h02, 32'h0800_0100);
    samp(24'h123456, 12'h123);
    rxchk(8'h50, 32'hFFFF_FFFF, 32'h1234_5603);
    rxchk(8'h50, 32'hFFFF_FFFF, 32'h1234_5602);
    devwr(1'b0, 8'h02, 32'h0000_0100);
    devwr(1'b0, 8'h30, 32'h5);
    samp(24'h123456, 12'h123);
    rxchk(8'h50, 32'hFFFF_FF00, 32'h1234_5100);
    devwr(1'b1, 8'h02, 32'h0000_0300);
    devwr(1'b1, 8'h02, 32'h0000_0100);
    rdchk(1'b1, 8'h02, 32'h300);
    devwr(1'b1, 8'h09, 32'h4);
    devwr(1'b1, 8'h09, 32'h0);
    rdchk(1'b1, 8'h09, 32'h4);
    for (int i = 1; i <= 8; i++) devwr(1'b1, 8'h30, i);
    rdchk(1'b1, 8'h30, 32'h7);
    rst();
    rdchk(1'b0, 8'h09, 32'h4);
    rdchk(1'b0, 8'h04, 32'h2000);
    rdchk(1'b0, 8'h30, 32'h7);
    rdchk(1'b0, 8'h02, 32'h300);
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
